//--- rtl/mcmr_top.sv
// Purpose: command byte decoder and operating configuration register
// Assumes: host frames each transaction with link_cs_n low; data sampled
//          on the falling link clock edge, driven after the rising one
// Notes:   link pins pass two flip-flops before any logic looks at them
`timescale 1ns/1ps
`default_nettype none
module mcmr_top (
  // clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 sys_rst,
  // serial link from host
  input  wire logic                 link_sclk,
  input  wire logic                 link_din,
  input  wire logic                 link_cs_n,
  output var  logic                 link_dout,
  output var  logic                 link_dout_oe,
  // configuration outputs
  output var  mcmr_pkg::mcmr_mode_t mode_cfg,
  output var  logic                 soft_reset_pulse,
  output var  logic                 link_holdoff,
  output var  logic                 waveform_update_stb,
  // thermal sensor handshake
  input  wire logic                 thermal_conv_done
);
  import mcmr_pkg::*;

  typedef enum logic [1:0] {ST_CMD, ST_DATA, ST_HOLD} mcmr_state_t;

  // ------------------------------------------------------------------
  // link synchronisers
  // ------------------------------------------------------------------
  logic [2:0] sclk_sync_r;
  logic [1:0] din_sync_r;
  logic [1:0] cs_sync_r;

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      sclk_sync_r <= 3'h0;
      din_sync_r  <= 2'h0;
      cs_sync_r   <= 2'h3;
    end
    else
    begin
      sclk_sync_r <= {sclk_sync_r[1:0], link_sclk};
      din_sync_r  <= {din_sync_r[0], link_din};
      cs_sync_r   <= {cs_sync_r[0], link_cs_n};
    end
  end

  wire logic sclk_fall = sclk_sync_r[2] & ~sclk_sync_r[1];
  wire logic sclk_rise = ~sclk_sync_r[2] & sclk_sync_r[1];
  wire logic din_s     = din_sync_r[1];
  wire logic cs_idle   = cs_sync_r[1];

  // ------------------------------------------------------------------
  // transfer state
  // ------------------------------------------------------------------
  mcmr_state_t        state_r;
  mcmr_state_t        state_nxt;
  logic [3:0]         bit_cnt_r;
  logic [DATA_W-1:0]  shift_r;
  logic [DATA_W-1:0]  tx_r;
  mcmr_cmd_t          cmd_r;
  logic [HOLD_W-1:0]  hold_cnt_r;
  mcmr_mode_t         mode_r;
  mcmr_mode_t         mode_nxt;
  logic [DIV_W-1:0]   div_cnt_r;

  wire mcmr_cmd_t   cmd_next  = mcmr_cmd_t'({shift_r[CMD_W-2:0], din_s});
  wire logic [15:0] data_next = {shift_r[DATA_W-2:0], din_s};
  wire logic in_cmd  = (state_r == ST_CMD) & ~cs_idle;
  wire logic in_data = (state_r == ST_DATA) & ~cs_idle;
  wire logic cmd_done  = in_cmd & sclk_fall & (bit_cnt_r == CMD_LAST);
  wire logic data_done = in_data & sclk_fall & (bit_cnt_r == DATA_LAST);
  wire logic cfg_hit   = cmd_r.target_register_index == OPCFG_ADDR;
  wire logic cfg_write = data_done & cmd_r.write_dir & cfg_hit;
  wire logic soft_chip_reset_fire = cfg_write & data_next[SOFT_CHIP_RESET_BIT];
  wire logic [DATA_W-1:0] read_word =
    (cmd_next.target_register_index == OPCFG_ADDR) ? mode_r : ZERO_WORD;
  wire logic hold_end = (state_r == ST_HOLD) & (hold_cnt_r == '0);

  // ------------------------------------------------------------------
  // state machine
  // ------------------------------------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_CMD:
      begin
        if (cmd_done)
          state_nxt = ST_DATA;
      end
      ST_DATA:
      begin
        if (cs_idle | data_done)
          state_nxt = ST_CMD;
      end
      ST_HOLD:
      begin
        if (hold_end)
          state_nxt = ST_CMD;
      end
      default:
        state_nxt = ST_CMD;
    endcase
    if (soft_chip_reset_fire)
      state_nxt = ST_HOLD;
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      state_r <= ST_CMD;
    else
      state_r <= state_nxt;
  end

  // bit counter restarts whenever the frame drops, so a torn frame
  // never leaves the decoder mid-byte
  always_ff @(posedge core_clk)
  begin
    if (sys_rst | cs_idle | cmd_done | data_done | state_r == ST_HOLD)
      bit_cnt_r <= 4'h0;
    else if (sclk_fall)
      bit_cnt_r <= bit_cnt_r + 4'h1;
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      shift_r <= ZERO_WORD;
    else if (sclk_fall & (in_cmd | in_data))
      shift_r <= data_next;
  end

  // command is latched only, never offered back on the link
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      cmd_r <= mcmr_cmd_t'(8'h00);
    else if (cmd_done)
      cmd_r <= cmd_next;
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst | soft_chip_reset_fire)
      hold_cnt_r <= HOLD_LOAD;
    else if (state_r == ST_HOLD & ~hold_end)
      hold_cnt_r <= hold_cnt_r - 12'h001;
  end

  // ------------------------------------------------------------------
  // read path
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      tx_r <= ZERO_WORD;
    else if (cmd_done)
      tx_r <= read_word;
    else if (in_data & sclk_rise)
      tx_r <= {tx_r[DATA_W-2:0], 1'b0};
  end

  always_ff @(posedge core_clk)
  begin
    // the last read bit must not linger into the next command byte
    if (sys_rst | ~in_data | data_done | cmd_r.write_dir)
      link_dout <= 1'b0;
    else if (sclk_rise)
      link_dout <= tx_r[DATA_W-1];
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      link_dout_oe <= 1'b0;
    else
      link_dout_oe <= in_data & ~cmd_r.write_dir & ~data_done;
  end

  // ------------------------------------------------------------------
  // operating configuration register
  // ------------------------------------------------------------------
  // a host write landing with the conversion-done pulse wins, so a
  // fresh start request is never swallowed
  always_comb
  begin
    mode_nxt = mode_r;
    if (thermal_conv_done)
      mode_nxt.thermal_conversion_start = 1'b0;
    if (cfg_write)
      mode_nxt = mcmr_mode_t'(data_next);
    if (soft_chip_reset_fire)
      mode_nxt = mcmr_mode_t'(OPCFG_RST);
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      mode_r <= mcmr_mode_t'(OPCFG_RST);
    else
      mode_r <= mode_nxt;
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      mode_cfg <= mcmr_mode_t'(OPCFG_RST);
    else
      mode_cfg <= mode_r;
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      soft_reset_pulse <= 1'b0;
      link_holdoff     <= 1'b0;
    end
    else
    begin
      soft_reset_pulse <= soft_chip_reset_fire;
      link_holdoff     <= state_nxt == ST_HOLD;
    end
  end

  // ------------------------------------------------------------------
  // waveform update divider
  // ------------------------------------------------------------------
  wire logic [DIV_W-1:0] rate_mask =
    DIV_W'({RATE_BASE_MASK, 3'h7} >> (2'h3 - mode_r.waveform_rate_select));
  wire logic rate_hit = (div_cnt_r & rate_mask) == rate_mask;

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      div_cnt_r           <= '0;
      waveform_update_stb <= 1'b0;
    end
    else
    begin
      div_cnt_r           <= div_cnt_r + 10'h001;
      waveform_update_stb <= rate_hit;
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  sequence s_cfg_reset;
    soft_chip_reset_fire ##1 (soft_reset_pulse && state_r == ST_HOLD);
  endsequence

  a_cmd_no_read: assert property (
    (state_r == ST_CMD) |-> !link_dout && !link_dout_oe)
    else $error("link driven during command byte");

  a_frame_cmd_first: assert property (
    $rose(cs_idle) && state_r != ST_HOLD |=> state_r == ST_CMD
      && bit_cnt_r == 4'h0)
    else $error("frame end did not rearm command phase");

  a_addr_taken: assert property (
    cmd_done |=> cmd_r.target_register_index ==
      $past(cmd_next.target_register_index))
    else $error("target index not latched");

  a_dir_taken: assert property (
    cmd_done |=> state_r == ST_DATA
      && cmd_r.write_dir == $past(cmd_next.write_dir))
    else $error("direction not latched");

  a_cfg_write: assert property (
    cfg_write && !soft_chip_reset_fire |=> mode_r == $past(data_next)
      ##1 mode_cfg == $past(mode_r))
    else $error("configuration write lost");

  a_reset_vals: assert property (
    $fell(sys_rst) |-> mode_r == OPCFG_RST && mode_cfg.pulse_output_off
      && mode_cfg.dip_detect_off && !mode_cfg.current_highpass_bypass)
    else $error("configuration reset value wrong");

  a_temp_clear: assert property (
    thermal_conv_done && !cfg_write |=> !mode_r.thermal_conversion_start)
    else $error("thermal start bit not cleared");

  a_soft_chip_reset_hold: assert property (
    s_cfg_reset |=> (state_r == ST_HOLD && link_holdoff)[*8]
      ##0 mode_r == OPCFG_RST)
    else $error("soft reset holdoff missing");

  a_rate_period: assert property (
    waveform_update_stb ##127
      (mode_r.waveform_rate_select == 2'b00) |=> waveform_update_stb)
    else $error("waveform strobe period wrong");

  a_back_to_cmd: assert property (
    data_done && !soft_chip_reset_fire |=> state_r == ST_CMD && bit_cnt_r == 4'h0)
    else $error("no return to command phase");

endmodule
`default_nettype wire

//--- rtl/mcmr_pkg.sv
// Purpose: shared constants and types for the meter command and mode block
// Assumes: 125 MHz core clock, serial link sampled by that clock
// Notes:   every data transfer after a command byte is 16 bits long
package mcmr_pkg;

  // ------------------------------------------------------------------
  // command byte layout
  // ------------------------------------------------------------------
  localparam int unsigned CMD_W      = 8;
  localparam int unsigned ADDR_W     = 6;
  localparam int unsigned DIR_BIT    = 7;
  localparam int unsigned RSV_BIT    = 6;

  typedef struct packed {
    logic              write_dir;
    logic              unused_zero;
    logic [ADDR_W-1:0] target_register_index;
  } mcmr_cmd_t;

  // ------------------------------------------------------------------
  // register map and data transfer
  // ------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OPCFG_ADDR = 6'h09;
  localparam int unsigned       DATA_W     = 16;
  localparam logic [3:0]        CMD_LAST   = 4'h7;
  localparam logic [3:0]        DATA_LAST  = 4'hf;
  localparam logic [15:0]       OPCFG_RST  = 16'h000c;
  localparam logic [15:0]       ZERO_WORD  = 16'h0000;

  // field positions of the operating configuration register
  localparam int unsigned HPF_BIT    = 0;
  localparam int unsigned LPF_BIT    = 1;
  localparam int unsigned PULSE_BIT  = 2;
  localparam int unsigned DIP_BIT    = 3;
  localparam int unsigned SUSP_BIT   = 4;
  localparam int unsigned TEMP_BIT   = 5;
  localparam int unsigned SOFT_CHIP_RESET_BIT  = 6;
  localparam int unsigned CYC_BIT    = 7;
  localparam int unsigned SWAP_BIT   = 10;
  localparam int unsigned RATE_LSB   = 11;

  typedef struct packed {
    logic [2:0] upper_hold;
    logic [1:0] waveform_rate_select;
    logic       channel_swap;
    logic       ch2_inputs_short;
    logic       ch1_inputs_short;
    logic       line_period_accumulate;
    logic       soft_chip_reset;
    logic       thermal_conversion_start;
    logic       converters_powerdown;
    logic       dip_detect_off;
    logic       pulse_output_off;
    logic       power_lowpass_bypass;
    logic       current_highpass_bypass;
  } mcmr_mode_t;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned SOFT_CHIP_RESET_HOLD_NS = 18000;
  localparam int unsigned HOLD_CYC =
    (SOFT_CHIP_RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned HOLD_W = 12;
  localparam logic [HOLD_W-1:0] HOLD_LOAD = 12'(HOLD_CYC - 1);
  localparam int unsigned DIV_W = 10;
  localparam logic [DIV_W-1:0] RATE_BASE_MASK = 10'h07f;

endpackage

//--- sim/mcmr_host_model.sv
// Purpose: host model driving the serial link of the command block
// Assumes: link clock idles low, 160 ns period, stepped on core_clk falls
// Notes:   the bench calls xfer; keep_holdoff can be lowered to break the wait
`timescale 1ns/1ps
`default_nettype none
module mcmr_host_model (
  // clock reference
  input  wire logic core_clk,
  // serial link
  output var  logic link_sclk,
  output var  logic link_din,
  output var  logic link_cs_n,
  input  wire logic link_dout,
  input  wire logic link_dout_oe
);
  import mcmr_pkg::*;
  logic [15:0] rd_word;
  logic        oe_seen;
  logic        keep_holdoff = 1'b1;

  initial
  begin
    link_sclk = 1'b0;
    link_din  = 1'b0;
    link_cs_n = 1'b1;
  end

  task automatic half();
    repeat (10) @(negedge core_clk);
  endtask

  // --------------------------------------------------------------------
  // one frame: command byte, then data bits msb first; under 24 aborts
  // --------------------------------------------------------------------
  task automatic xfer(input logic [7:0] cmd, input logic [15:0] wdata,
                      input int nbits);
    logic [23:0] sh;
    sh        = {cmd & 8'hbf, wdata};
    oe_seen   = 1'b0;
    link_cs_n = 1'b0;
    half();
    for (int i = 0; i < nbits; i++)
    begin
      link_sclk = 1'b1;
      link_din  = sh[23-i];
      half();
      link_sclk = 1'b0;
      rd_word   = {rd_word[14:0], link_dout};
      oe_seen   = oe_seen | (link_dout_oe & (i >= 8));
      half();
    end
    // no pull on the data line, so a released line must not keep its level
    link_din  = ~link_din;
    link_cs_n = 1'b1;
    half();
    if (keep_holdoff && cmd[7] && cmd[5:0] == OPCFG_ADDR && wdata[SOFT_CHIP_RESET_BIT])
      repeat (HOLD_CYC) @(negedge core_clk);
  endtask
endmodule
`default_nettype wire

//--- sim/mcmr_top_test.sv
// Purpose: self-checking bench for the command and configuration block
// Assumes: host model steps the link on core_clk falls
// Notes:   each test is a task; a watchdog ends a hung run
`timescale 1ns/1ps
`default_nettype none
module mcmr_top_test;
  import mcmr_pkg::*;
  logic       core_clk;
  logic       sys_rst;
  logic       link_sclk;
  logic       link_din;
  logic       link_cs_n;
  logic       link_dout;
  logic       link_dout_oe;
  mcmr_mode_t mode_cfg;
  logic       soft_reset_pulse;
  logic       link_holdoff;
  logic       waveform_update_stb;
  logic       thermal_conv_done;
  int         n_mismatch = 0;
  int         n_checks = 0;
  int         n_srst = 0;

  mcmr_top dut (.core_clk(core_clk), .sys_rst(sys_rst),
    .link_sclk(link_sclk), .link_din(link_din), .link_cs_n(link_cs_n),
    .link_dout(link_dout), .link_dout_oe(link_dout_oe),
    .mode_cfg(mode_cfg), .soft_reset_pulse(soft_reset_pulse),
    .link_holdoff(link_holdoff), .waveform_update_stb(waveform_update_stb),
    .thermal_conv_done(thermal_conv_done));
  mcmr_host_model host (.core_clk(core_clk), .link_sclk(link_sclk),
    .link_din(link_din), .link_cs_n(link_cs_n), .link_dout(link_dout),
    .link_dout_oe(link_dout_oe));

  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // the pulse lasts one cycle, so count it rather than sample it later
  always @(posedge core_clk)
    if (soft_reset_pulse === 1'b1)
      n_srst <= n_srst + 1;

  // --------------------------------------------------------------------
  // shared tasks
  // --------------------------------------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    host.xfer({2'b10, a}, d, 24);
    repeat (8) @(negedge core_clk);
  endtask

  // all-ones on the data line: a read taken as a write would show
  task automatic rd(input logic [5:0] a);
    host.xfer({2'b00, a}, 16'hffff, 24);
  endtask

  task automatic stb_gap(output int k);
    k = 0;
    do
    begin
      @(negedge core_clk);
      k++;
    end
    while (waveform_update_stb !== 1'b1 && k < 2000);
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // --------------------------------------------------------------------
  // tests
  // --------------------------------------------------------------------
  task automatic t_reset();
    check(mode_cfg, OPCFG_RST);
    check({15'h0, link_dout_oe}, ZERO_WORD);
    rd(OPCFG_ADDR);
    check(host.rd_word, OPCFG_RST);
    check({15'h0, host.oe_seen}, 16'h0001);
    check(mode_cfg, OPCFG_RST);
    $display("test reset done");
  endtask

  task automatic t_fields();
    logic [15:0] v [8] = '{16'h0001, 16'h0002, 16'h0004, 16'h0008,
                           16'h0010, 16'h0080, 16'h0400, 16'h1800};
    foreach (v[i])
    begin
      wr(OPCFG_ADDR, v[i]);
      check(mode_cfg, v[i]);
      rd(OPCFG_ADDR);
      check(host.rd_word, v[i]);
    end
    $display("test fields done");
  endtask

  task automatic t_other();
    wr(6'h0a, 16'h5555);
    check(mode_cfg, 16'h1800);
    wr(6'h29, 16'h0003);
    check(mode_cfg, 16'h1800);
    rd(6'h0a);
    check(host.rd_word, ZERO_WORD);
    $display("test other done");
  endtask

  task automatic t_thermal();
    wr(OPCFG_ADDR, 16'h0020);
    repeat (20) @(negedge core_clk);
    check(mode_cfg, 16'h0020);
    thermal_conv_done = 1'b1;
    @(negedge core_clk);
    thermal_conv_done = 1'b0;
    repeat (3) @(negedge core_clk);
    check(mode_cfg, ZERO_WORD);
    $display("test thermal done");
  endtask

  task automatic t_rate();
    int k;
    for (int r = 0; r < 4; r++)
    begin
      wr(OPCFG_ADDR, 16'(r) << RATE_LSB);
      stb_gap(k);
      stb_gap(k);
      check(16'(k), 16'(128 << r));
    end
    $display("test rate done");
  endtask

  task automatic t_abort();
    host.xfer({2'b10, OPCFG_ADDR}, 16'h0003, 16);
    check(mode_cfg, 16'h1800);
    wr(OPCFG_ADDR, 16'h0002);
    check(mode_cfg, 16'h0002);
    $display("test abort done");
  endtask

  task automatic t_soft_chip_reset();
    host.keep_holdoff = 1'b0;
    wr(OPCFG_ADDR, 16'h0041);
    check(16'(n_srst), 16'h0001);
    check(mode_cfg, OPCFG_RST);
    check({15'h0, link_holdoff}, 16'h0001);
    wr(OPCFG_ADDR, 16'h0001);
    check(mode_cfg, OPCFG_RST);
    host.keep_holdoff = 1'b1;
    repeat (HOLD_CYC) @(negedge core_clk);
    check({15'h0, link_holdoff}, ZERO_WORD);
    wr(OPCFG_ADDR, 16'h0002);
    check(mode_cfg, 16'h0002);
    $display("test soft reset done");
  endtask

  initial
  begin
    sys_rst = 1'b1;
    thermal_conv_done = 1'b0;
    repeat (10) @(negedge core_clk);
    sys_rst = 1'b0;
    repeat (3) @(negedge core_clk);
    t_reset();
    t_fields();
    t_other();
    t_thermal();
    t_rate();
    t_abort();
    t_soft_chip_reset();
    test_done();
  end

  initial
  begin
    repeat (60000) @(posedge core_clk);
    n_mismatch++;
    test_done();
  end
endmodule
`default_nettype wire
